// >>> design/hbi3_dev.sv
// Device end of the three-style processor port with its byte-wide memory map.
`timescale 1ns/100ps
module hbi3_dev (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire logic i_ce, // Clock enable; freezes all state but the write pulse, which clears, when low.
  hbi3_if.dev bus, // Processor pins.
  input wire logic i_irq_event, // Internal interrupt request level.
  output logic o_irq_active, // Registered interrupt state, active high.
  output logic o_wr_pulse, // One-cycle pulse on each stored write.
  output logic [10:0] o_last_addr // Address of the last accepted access, loaded when the request is taken.
);
  // ==========================================================================
  // Pin synchronisers: two flops before any logic looks at a pin.
  localparam int unsigned SW = 27;
  // Reset image of the chain: select and both strobes sit at their inactive high level,
  // so no phantom access is decoded in the two cycles before the real pins arrive.
  localparam logic [SW-1:0] SYNC_IDLE = 27'h000001C;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync1_d;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync2_d;

  // The upper address lines are only ever sampled, never driven.
  assign pin_raw = {bus.mux_strap, bus.split_style_strap, bus.irq_polarity_pin,
                    bus.upper_address_lines, bus.addr_lo, bus.shared_addr_data_lines,
                    bus.sel_n, bus.rd_n, bus.wr_n, bus.ale, i_irq_event};

  // Next values of the synchroniser chain.
  always_comb begin
    sync1_d = i_ce ? pin_raw : sync1_q;
    sync2_d = i_ce ? sync1_q : sync2_q;
  end

  // Register the synchroniser chain.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic s_mux;
  logic s_style;
  logic s_pol;
  logic [2:0] s_upper;
  logic [7:0] s_alo;
  logic [7:0] s_ad;
  logic s_sel_n;
  logic s_rd_n;
  logic s_wr_n;
  logic s_ale;
  logic s_irq;
  assign {s_mux, s_style, s_pol, s_upper, s_alo, s_ad, s_sel_n, s_rd_n, s_wr_n, s_ale,
          s_irq} = sync2_q;

  // ==========================================================================
  // Style decode and request decode.
  hbi3_pkg::hbi3_style_t style;
  logic int_sel_n;
  logic req_rd;
  logic req_wr;
  logic [10:0] cur_addr;
  logic [7:0] lo_addr_q;
  logic [7:0] lo_addr_d;
  logic ale_q;
  logic ale_d;

  // Multiplexed style wins over the split-style strap.
  always_comb begin
    if (s_mux) begin
      style = hbi3_pkg::HBI3_STYLE_MUX;
    end else if (s_style) begin
      style = hbi3_pkg::HBI3_STYLE_SPLIT_DIR;
    end else begin
      style = hbi3_pkg::HBI3_STYLE_SPLIT_SEP;
    end
  end

  // Requests per style; the direction style ORs select with the auxiliary strobe.
  always_comb begin
    int_sel_n = s_sel_n;
    req_rd = 1'b0;
    req_wr = 1'b0;
    cur_addr = {s_upper, s_alo};
    unique case (style)
      hbi3_pkg::HBI3_STYLE_MUX: begin
        cur_addr = {s_upper, lo_addr_q};
        req_rd = !s_sel_n && !s_rd_n;
        req_wr = !s_sel_n && !s_wr_n;
      end
      hbi3_pkg::HBI3_STYLE_SPLIT_SEP: begin
        req_rd = !s_sel_n && !s_rd_n;
        req_wr = !s_sel_n && !s_wr_n;
      end
      hbi3_pkg::HBI3_STYLE_SPLIT_DIR: begin
        int_sel_n = s_sel_n | s_wr_n;
        req_rd = !int_sel_n && s_rd_n;
        req_wr = !int_sel_n && !s_rd_n;
      end
    endcase
  end

  // The low address byte is caught as the latch strobe falls and held until the next one.
  always_comb begin
    ale_d = i_ce ? s_ale : ale_q;
    lo_addr_d = lo_addr_q;
    if (i_ce && ale_q && !s_ale) begin
      lo_addr_d = s_ad;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ale_q <= 1'b0;
      lo_addr_q <= hbi3_pkg::DATA_RST;
    end else begin
      ale_q <= ale_d;
      lo_addr_q <= lo_addr_d;
    end
  end

  // ==========================================================================
  // Access engine. Ready stays low until the byte is settled, so the host waits.
  typedef enum logic [1:0] {HBI3_IDLE, HBI3_BUSY, HBI3_DONE} hbi3_acc_t;
  hbi3_acc_t st_q;
  hbi3_acc_t st_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic is_rd_q;
  logic is_rd_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic drive_q;
  logic drive_d;
  logic ready_q;
  logic ready_d;
  logic ack_n_q;
  logic ack_n_d;
  logic wr_pulse_q;
  logic wr_pulse_d;
  logic [10:0] last_q;
  logic [10:0] last_d;
  logic [7:0] mem [hbi3_pkg::MEM_DEPTH];
  logic mem_we;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    is_rd_d = is_rd_q;
    rd_data_d = rd_data_q;
    drive_d = drive_q;
    ready_d = ready_q;
    ack_n_d = ack_n_q;
    wr_pulse_d = 1'b0;
    last_d = last_q;
    mem_we = 1'b0;
    if (i_ce) begin
      unique case (st_q)
        HBI3_IDLE: begin
          ready_d = 1'b1;
          ack_n_d = 1'b1;
          if (req_rd || req_wr) begin
            st_d = HBI3_BUSY;
            is_rd_d = req_rd;
            cnt_d = 2'(hbi3_pkg::ACC_CYC - 1);
            ready_d = 1'b0;
            last_d = cur_addr;
          end
        end
        HBI3_BUSY: begin
          if (cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
          end else begin
            st_d = HBI3_DONE;
            ready_d = 1'b1;
            if (is_rd_q) begin
              rd_data_d = mem[last_q];
              drive_d = 1'b1;
            end else begin
              mem_we = 1'b1;
              wr_pulse_d = 1'b1;
            end
            ack_n_d = (style != hbi3_pkg::HBI3_STYLE_SPLIT_DIR);
          end
        end
        HBI3_DONE: begin
          if (!req_rd && !req_wr) begin
            st_d = HBI3_IDLE;
            drive_d = 1'b0;
            ack_n_d = 1'b1;
          end
        end
        default: begin
          st_d = HBI3_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q <= HBI3_IDLE;
      cnt_q <= 2'h0;
      is_rd_q <= 1'b0;
      rd_data_q <= hbi3_pkg::DATA_RST;
      drive_q <= 1'b0;
      ready_q <= 1'b1;
      ack_n_q <= 1'b1;
      wr_pulse_q <= 1'b0;
      last_q <= hbi3_pkg::ADDR_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      is_rd_q <= is_rd_d;
      rd_data_q <= rd_data_d;
      drive_q <= drive_d;
      ready_q <= ready_d;
      ack_n_q <= ack_n_d;
      wr_pulse_q <= wr_pulse_d;
      last_q <= last_d;
    end
  end

  // Memory array has no reset; contents are whatever software last wrote.
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem[last_q] <= s_ad;
    end
  end

  // ==========================================================================
  // Interrupt output with strap-selected polarity.
  logic irq_q;
  logic irq_d;
  logic irq_act_q;
  logic irq_act_d;

  always_comb begin
    irq_act_d = i_ce ? s_irq : irq_act_q;
    irq_d = i_ce ? (s_pol ? s_irq : !s_irq) : irq_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_q <= 1'b0;
      irq_act_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      irq_act_q <= irq_act_d;
    end
  end

  // Outputs straight from flops; the output enable is low while driving.
  assign bus.dev_data_out = rd_data_q;
  assign bus.dev_data_oe_n = !drive_q;
  assign bus.ready = ready_q;
  assign bus.transfer_acknowledge_n = ack_n_q;
  assign bus.irq = irq_q;
  assign o_irq_active = irq_act_q;
  assign o_wr_pulse = wr_pulse_q;
  assign o_last_addr = last_q;
endmodule : hbi3_dev

// >>> design/hbi3_host.sv
// Processor end of the three-style port: runs one read or write per request.
`timescale 1ns/100ps
module hbi3_host (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire logic i_ce, // Clock enable; freezes all state when low.
  hbi3_if.host bus, // Processor pins.
  input wire logic i_mux_strap, // Multiplexed style strap.
  input wire logic i_style_strap, // Split style strap.
  input wire logic i_irq_pol, // Interrupt polarity strap.
  input wire logic i_req, // Start a transfer, level sampled in idle.
  input wire logic i_req_wr, // High for a write.
  input wire logic [10:0] i_addr, // Transfer address.
  input wire logic [7:0] i_wdata, // Write data.
  output logic o_busy, // Transfer or bus turnaround in progress.
  output logic o_done, // One-cycle pulse when transfer ends.
  output logic [7:0] o_rdata // Byte on the data lines at the end of the last transfer, read or write.
);
  // ==========================================================================
  // Ready and acknowledge pins from the device pass two flops.
  logic [1:0] rdy_s_q;
  logic [1:0] ack_s_q;
  logic [1:0] rdy_s_d;
  logic [1:0] ack_s_d;

  always_comb begin
    rdy_s_d = i_ce ? {rdy_s_q[0], bus.ready} : rdy_s_q;
    ack_s_d = i_ce ? {ack_s_q[0], bus.transfer_acknowledge_n} : ack_s_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdy_s_q <= 2'h0;
      ack_s_q <= 2'h3;
    end else begin
      rdy_s_q <= rdy_s_d;
      ack_s_q <= ack_s_d;
    end
  end

  // Done when ready is seen, or acknowledge low in the direction style.
  logic dev_done;
  assign dev_done = (i_mux_strap || !i_style_strap) ? rdy_s_q[1] : !ack_s_q[1];

  // ==========================================================================
  // Host sequencer.
  typedef enum logic [2:0] {HBI3_H_IDLE, HBI3_H_ADDR, HBI3_H_LATCH, HBI3_H_STROBE,
                            HBI3_H_WAIT, HBI3_H_END} hbi3_hst_t;
  hbi3_hst_t st_q;
  hbi3_hst_t st_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic wr_q;
  logic wr_d;
  logic [10:0] addr_q;
  logic [10:0] addr_d;
  logic [7:0] wdat_q;
  logic [7:0] wdat_d;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic done_q;
  logic done_d;
  logic ale_q;
  logic ale_d;
  logic sel_n_q;
  logic sel_n_d;
  logic rd_n_q;
  logic rd_n_d;
  logic wr_n_q;
  logic wr_n_d;
  logic hoe_n_q;
  logic hoe_n_d;
  logic [7:0] hout_q;
  logic [7:0] hout_d;
  logic timeout;
  // Set once the device has shown it is not yet done; a stale ready is never trusted.
  logic seen_q;
  logic seen_d;

  assign timeout = (cnt_q == 3'h0);

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 3'h0) ? cnt_q - 3'h1 : cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    done_d = 1'b0;
    seen_d = seen_q;
    ale_d = ale_q;
    sel_n_d = sel_n_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    hoe_n_d = hoe_n_q;
    hout_d = hout_q;
    unique case (st_q)
      HBI3_H_IDLE: begin
        if (i_req && timeout) begin // Bus turnaround after the last access.
          wr_d = i_req_wr;
          addr_d = i_addr;
          wdat_d = i_wdata;
          cnt_d = 3'(hbi3_pkg::PHASE_CYC);
          if (i_mux_strap) begin
            st_d = HBI3_H_ADDR;
            ale_d = 1'b1;
            hout_d = i_addr[7:0];
            hoe_n_d = 1'b0;
          end else begin
            st_d = HBI3_H_STROBE;
          end
        end
      end
      HBI3_H_ADDR: begin
        if (timeout) begin
          st_d = HBI3_H_LATCH;
          ale_d = 1'b0;
          cnt_d = 3'(hbi3_pkg::PHASE_CYC);
        end
      end
      HBI3_H_LATCH: begin
        if (timeout) begin
          st_d = HBI3_H_STROBE;
          hoe_n_d = 1'b1;
        end
      end
      HBI3_H_STROBE: begin
        st_d = HBI3_H_WAIT;
        seen_d = 1'b0;
        sel_n_d = 1'b0;
        hout_d = wdat_q;
        hoe_n_d = !wr_q;
        if (!i_mux_strap && i_style_strap) begin
          rd_n_d = !wr_q;
          wr_n_d = 1'b0;
        end else begin
          rd_n_d = wr_q;
          wr_n_d = !wr_q;
        end
        cnt_d = 3'(hbi3_pkg::PHASE_CYC);
      end
      HBI3_H_WAIT: begin
        if (!dev_done) begin
          seen_d = 1'b1;
        end
        if (timeout && dev_done && seen_q) begin
          st_d = HBI3_H_END;
          rdat_d = bus.shared_addr_data_lines;
        end
      end
      HBI3_H_END: begin
        st_d = HBI3_H_IDLE;
        sel_n_d = 1'b1;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        hoe_n_d = 1'b1;
        done_d = 1'b1;
        // The device keeps driving read data until it sees the strobes go, so wait.
        cnt_d = 3'(hbi3_pkg::PHASE_CYC);
      end
      default: begin
        st_d = HBI3_H_IDLE;
      end
    endcase
    if (!i_ce) begin
      st_d = st_q;
      cnt_d = cnt_q;
      rdat_d = rdat_q;
      done_d = done_q;
      seen_d = seen_q;
      {wr_d, addr_d, wdat_d, ale_d, sel_n_d, rd_n_d, wr_n_d, hoe_n_d, hout_d} =
        {wr_q, addr_q, wdat_q, ale_q, sel_n_q, rd_n_q, wr_n_q, hoe_n_q, hout_q};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q <= HBI3_H_IDLE;
      cnt_q <= 3'h0;
      wr_q <= 1'b0;
      addr_q <= hbi3_pkg::ADDR_RST;
      wdat_q <= hbi3_pkg::DATA_RST;
      rdat_q <= hbi3_pkg::DATA_RST;
      done_q <= 1'b0;
      seen_q <= 1'b0;
      ale_q <= 1'b0;
      sel_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      hoe_n_q <= 1'b1;
      hout_q <= hbi3_pkg::DATA_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
      seen_q <= seen_d;
      ale_q <= ale_d;
      sel_n_q <= sel_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      hoe_n_q <= hoe_n_d;
      hout_q <= hout_d;
    end
  end

  // Pin drives; upper bits always come from the held address.
  assign bus.mux_strap = i_mux_strap;
  assign bus.split_style_strap = i_style_strap;
  assign bus.irq_polarity_pin = i_irq_pol;
  assign bus.upper_address_lines = addr_q[10:8];
  assign bus.addr_lo = addr_q[7:0];
  assign bus.host_data_out = hout_q;
  assign bus.host_data_oe_n = hoe_n_q;
  assign bus.sel_n = sel_n_q;
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.ale = ale_q;
  assign o_busy = (st_q != HBI3_H_IDLE) || !timeout;
  assign o_done = done_q;
  assign o_rdata = rdat_q;
endmodule : hbi3_host

// >>> pkg/hbi3_if.sv
// Interface carrying the processor pins between the host end and the device end.
`timescale 1ns/100ps
interface hbi3_if;
  logic mux_strap;
  logic split_style_strap;
  logic irq_polarity_pin;
  logic [2:0] upper_address_lines;
  logic [7:0] addr_lo;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic [7:0] dev_data_out;
  logic dev_data_oe_n;
  logic [7:0] shared_addr_data_lines;
  logic sel_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic ready;
  logic transfer_acknowledge_n;
  logic irq;

  // Resolve the shared data lines; an undriven bus reads as zero.
  always_comb begin
    if (!dev_data_oe_n) begin
      shared_addr_data_lines = dev_data_out;
    end else if (!host_data_oe_n) begin
      shared_addr_data_lines = host_data_out;
    end else begin
      shared_addr_data_lines = hbi3_pkg::DATA_RST;
    end
  end

  modport dev (
    input mux_strap, split_style_strap, irq_polarity_pin, upper_address_lines, addr_lo,
    input shared_addr_data_lines, sel_n, rd_n, wr_n, ale,
    output dev_data_out, dev_data_oe_n, ready, transfer_acknowledge_n, irq
  );
  modport host (
    output mux_strap, split_style_strap, irq_polarity_pin, upper_address_lines, addr_lo,
    output host_data_out, host_data_oe_n, sel_n, rd_n, wr_n, ale,
    input shared_addr_data_lines, ready, transfer_acknowledge_n, irq
  );
endinterface : hbi3_if

// >>> pkg/hbi3_pkg.sv
// Package with constants and types shared by both ends of the three-style host port.
package hbi3_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned UPPER_W = 3;
  localparam int unsigned MEM_DEPTH = 2048;
  // ==========================================================================
  // Field positions
  localparam int unsigned UPPER_LSB = 8;
  localparam int unsigned UPPER_MSB = 10;
  localparam int unsigned LOW_MSB = 7;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [10:0] ADDR_RST = 11'h000;
  // ==========================================================================
  // Host timing: cycles each strobe phase is held by the host end.
  localparam int unsigned PHASE_CYC = 4;
  // Device access latency before ready or acknowledge is given.
  localparam int unsigned ACC_CYC = 2;

  // Bus style chosen by the two straps.
  typedef enum logic [1:0] {
    HBI3_STYLE_MUX,
    HBI3_STYLE_SPLIT_SEP,
    HBI3_STYLE_SPLIT_DIR
  } hbi3_style_t;
endpackage : hbi3_pkg

// >>> tb/hbi3_asserts.sv
// Concurrent checks on the processor pins joining the two ends of the host port.
`timescale 1ns/100ps
module hbi3_asserts (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire logic mux_strap, // Multiplexed style strap.
  input wire logic split_style_strap, // Split style strap.
  input wire logic host_data_oe_n, // Host data drive enable, low drives.
  input wire logic dev_data_oe_n, // Device data drive enable, low drives.
  input wire logic sel_n, // Device select.
  input wire logic rd_n, // Read strobe or direction line.
  input wire logic wr_n, // Write strobe or auxiliary strobe.
  input wire logic ale, // Address latch strobe.
  input wire logic ready, // Ready level.
  input wire logic transfer_acknowledge_n // Acknowledge, active low.
);
  // ==========================================================================
  // Decoded request kinds
  // The direction line reads high, so the read decode flips with the style.
  wire logic rd_cond = (mux_strap || !split_style_strap) ? !rd_n : rd_n;
  wire logic wr_cond = (mux_strap || !split_style_strap) ? !wr_n : !rd_n;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_start;
    $fell(sel_n);
  endsequence
  sequence s_wait;
    ##[1:4] !ready ##[1:6] ready;
  endsequence
  sequence s_write;
    !sel_n && wr_cond;
  endsequence

  // ==========================================================================
  // Properties
  AST_RDY_WAIT: assert property (s_start |-> s_wait)
    else $error("ready did not drop and recover around a transfer");
  AST_RDY_HOLD: assert property ($rose(ready) |-> ready[*4])
    else $error("ready fell again right after completing");
  AST_RD_DRIVE: assert property ($fell(dev_data_oe_n) |-> ready && !sel_n && rd_cond)
    else $error("device drove data outside a selected read");
  AST_WR_QUIET: assert property (s_write [*4] |-> dev_data_oe_n)
    else $error("device drove data during a write");
  AST_ONE_DRV: assert property (!(!dev_data_oe_n && !host_data_oe_n))
    else $error("both ends drive the data lines");
  AST_ALE_ADDR: assert property (ale |-> sel_n && mux_strap && !host_data_oe_n)
    else $error("latch strobe outside a multiplexed address phase");
  AST_ACK_STYLE: assert property (!transfer_acknowledge_n |-> !mux_strap && split_style_strap)
    else $error("acknowledge given outside direction style");
  AST_ACK_RISE: assert property ($rose(ready) && !mux_strap && split_style_strap
    |-> !transfer_acknowledge_n)
    else $error("acknowledge missing at completion");
  AST_RST_IDLE: assert property ($fell(i_srst) |-> ready && transfer_acknowledge_n
    && dev_data_oe_n && sel_n && !ale)
    else $error("pins not idle after reset");
endmodule : hbi3_asserts

// >>> tb/test_host_bus_interface_three_mode.sv
// Self-checking testbench joining the host end to the device end of the port.
`timescale 1ns/100ps
module test_host_bus_interface_three_mode;
  typedef struct {logic mux; logic sty; logic [10:0] a; logic [7:0] d;} hbi3_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic mux_s = 1'b1;
  logic sty_s = 1'b0;
  logic pol = 1'b1;
  logic req = 1'b0;
  logic req_wr = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00;
  logic irq_ev = 1'b0;
  logic busy;
  logic done;
  logic [7:0] rdata;
  logic irq_act;
  logic wr_p;
  logic wr_p2;
  logic [10:0] last_a;
  logic [10:0] last_a2;
  int errors = 0;
  int checks_done = 0;
  int wp1 = 0;
  int wp2 = 0;
  hbi3_row_t rows [5] = '{'{1'b1, 1'b0, 11'h7FF, 8'hA5}, '{1'b1, 1'b1, 11'h100, 8'h5A},
    '{1'b0, 1'b0, 11'h000, 8'hFF}, '{1'b0, 1'b1, 11'h4C3, 8'h01},
    '{1'b0, 1'b0, 11'h2B6, 8'h80}};

  hbi3_if bus_if ();
  hbi3_if bus2_if ();
  hbi3_dev hbi3_dev_inst (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .bus(bus_if),
    .i_irq_event(irq_ev), .o_irq_active(irq_act), .o_wr_pulse(wr_p), .o_last_addr(last_a));
  hbi3_host hbi3_host_inst (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .bus(bus_if),
    .i_mux_strap(mux_s), .i_style_strap(sty_s), .i_irq_pol(pol), .i_req(req),
    .i_req_wr(req_wr), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata));
  // A lone device end whose pins the bench drives, so the auxiliary strobe can misbehave.
  hbi3_dev hbi3_dev_inst_b (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .bus(bus2_if),
    .i_irq_event(1'b0), .o_irq_active(), .o_wr_pulse(wr_p2), .o_last_addr(last_a2));
  hbi3_asserts hbi3_asserts_inst (.i_ref_clk(clk), .i_srst(srst),
    .mux_strap(bus_if.mux_strap), .split_style_strap(bus_if.split_style_strap),
    .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
    .sel_n(bus_if.sel_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .ale(bus_if.ale),
    .ready(bus_if.ready), .transfer_acknowledge_n(bus_if.transfer_acknowledge_n));

  // ==========================================================================
  // Clock, write pulse counters and watchdog
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_p === 1'b1) wp1++;
    if (wr_p2 === 1'b1) wp2++;
  end
  // The whole sequence needs well under a thousand transfers' worth of cycles.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end

  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge clk);
    #1 srst = 1'b1;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
  endtask : do_reset

  // Requests one transfer and waits for the completion pulse under a bound.
  task automatic xfer(input logic wr, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    // The host refuses requests while busy or in bus turnaround, so wait until it is free.
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    req = 1'b1;
    req_wr = wr;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 req = 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    chk({10'h000, done}, 11'h001);
  endtask : xfer

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // ==========================================================================
  // Main sequence
  initial begin
    int w;
    bus2_if.mux_strap = 1'b0;
    bus2_if.split_style_strap = 1'b1;
    bus2_if.irq_polarity_pin = 1'b1;
    bus2_if.upper_address_lines = 3'h6;
    bus2_if.addr_lo = 8'hB1;
    bus2_if.host_data_out = 8'h3C;
    bus2_if.host_data_oe_n = 1'b1;
    bus2_if.sel_n = 1'b1;
    bus2_if.rd_n = 1'b1;
    bus2_if.wr_n = 1'b0;
    bus2_if.ale = 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({8'h00, bus_if.ready, bus_if.transfer_acknowledge_n, busy}, 11'h006);
    srst = 1'b0;
    // Each row is written and read back in its own style; every style appears.
    foreach (rows[i]) begin
      // Acknowledge is released a few cycles after the host lets go; let it settle first.
      wait_cyc(4);
      mux_s = rows[i].mux;
      sty_s = rows[i].sty;
      do_reset();
      w = wp1;
      xfer(1'b1, rows[i].a, rows[i].d);
      chk(last_a, rows[i].a);
      chk(wp1[10:0], w[10:0] + 11'h001);
      xfer(1'b0, rows[i].a, 8'h00);
      chk({3'h0, rdata}, {3'h0, rows[i].d});
    end
    // The map written in mixed styles must read the same in the separate-strobe style.
    mux_s = 1'b0;
    sty_s = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      xfer(1'b0, rows[i].a, 8'h00);
      chk({3'h0, rdata}, {3'h0, rows[i].d});
    end
    // Interrupt level for both polarities, idle then raised.
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      irq_ev = 1'b0;
      do_reset();
      wait_cyc(6);
      chk({10'h000, bus_if.irq}, {10'h000, ~pol});
      irq_ev = 1'b1;
      wait_cyc(6);
      chk({9'h000, bus_if.irq, irq_act}, {9'h000, pol, 1'b1});
    end
    irq_ev = 1'b0;
    // Lone device: a high auxiliary strobe must block a direction-style write.
    w = wp2;
    bus2_if.host_data_oe_n = 1'b0;
    bus2_if.rd_n = 1'b0;
    bus2_if.wr_n = 1'b1;
    bus2_if.sel_n = 1'b0;
    wait_cyc(20);
    chk(wp2[10:0], w[10:0]);
    chk({10'h000, bus2_if.ready}, 11'h001);
    bus2_if.wr_n = 1'b0;
    wait_cyc(12);
    chk(wp2[10:0], w[10:0] + 11'h001);
    chk(last_a2, 11'h6B1);
    bus2_if.sel_n = 1'b1;
    bus2_if.host_data_oe_n = 1'b1;
    wait_cyc(6);
    bus2_if.rd_n = 1'b1;
    bus2_if.sel_n = 1'b0;
    wait_cyc(12);
    chk({3'h0, bus2_if.shared_addr_data_lines}, 11'h03C);
    chk({10'h000, bus2_if.transfer_acknowledge_n}, 11'h000);
    bus2_if.sel_n = 1'b1;
    wait_cyc(6);
    test_done();
  end
endmodule : test_host_bus_interface_three_mode
